// *** inc/ftdc_pkg.sv ***
//
// Notes on behaviour
// RULE_01: Watermark level is five bits and resets to sixteen samples.
// RULE_02: Software programs the watermark between one and thirty-one.
// RULE_03: Upper three bits of the watermark register read as zero.
// RULE_04: Pending register: bit 0 empty, bit 1 full, bit 2 threshold.
// RULE_05: Each pending flag only sets while its enable bit is on.
// RULE_06: Upper five bits of the pending register read as zero.
// RULE_07: Front end keeps the internal rate; FIFO logic runs at output rate.
// RULE_08: Divisor select zero, its reset value, turns decimation off.
// RULE_09: Codes one to seven divide by 2, 4, 5, 8, 10, 16, 20.
// RULE_10: Codes eight to ten divide by 40, 67, 80; fifteen by 1000.
// RULE_11: With decimation off the output rate equals the internal rate.
// RULE_12: Output data register updates at the output rate.
// RULE_13: Decimator works on any base rate the timebase produces.
// RULE_14: Host sets burst mode before draining several samples.
// RULE_15: Single-sample reads work with burst mode cleared.
// RULE_16: With wrap enabled, burst address wraps at the selected address.
// RULE_17: Wrap from 0x12, or 0x14 when selected, back to 0x0d.
// RULE_18: With wrap disabled the address simply increments.
// RULE_19: Watermark mode drops samples once count reaches the level.
// RULE_20: Host programs the read count before a burst read.
// RULE_21: Software never writes zero to the watermark field.
// RULE_22: Flags follow FIFO state, recomputed each output sample and read.
//
package ftdc_pkg;
	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_WATERMARK = 8'h2e;
	localparam logic [7:0] ADDR_PENDING = 8'h2f;
	localparam logic [7:0] ADDR_BURST_DEC = 8'h30;
	localparam logic [7:0] WM_RESET = 8'h10;
	localparam logic [7:0] PENDING_RESET = 8'h00;
	localparam logic [7:0] BURST_DEC_RESET = 8'h00;
	localparam logic [7:0] BURST_DEC_WMASK = 8'hbf;
	localparam int WM_MSB = 4;
	localparam int DEC_MSB = 3;
	localparam int BIT_WRAP_N = 4;
	localparam int BIT_WRAP_SEL = 5;
	localparam int BIT_BURST = 7;
	localparam int BIT_EMPTY = 0;
	localparam int BIT_FULL = 1;
	localparam int BIT_LEVEL = 2;
	// -----------------------------------------------------------------
	// Burst address wrap points
	// -----------------------------------------------------------------
	localparam logic [7:0] WRAP_LO = 8'h12;
	localparam logic [7:0] WRAP_HI = 8'h14;
	localparam logic [7:0] WRAP_BASE = 8'h0d;
	// -----------------------------------------------------------------
	// FIFO and decimator sizes
	// -----------------------------------------------------------------
	localparam logic [5:0] FIFO_DEPTH = 6'h20;
	localparam int SAMPLE_W = 48;
	localparam int DEC_CNT_W = 10;
	// Control bits kept in the neighbouring control register
	typedef struct packed {
		logic fifo_enable;
		logic watermark_mode;
		logic fifo_flush;
		logic level_irq_enable;
		logic full_irq_enable;
		logic empty_irq_enable;
	} ftdc_ctrl_s;
endpackage

// *** hdl/ftdc_ctrl.sv ***
`timescale 1ns/10ps
module ftdc_ctrl
	import ftdc_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	input wire ftdc_ctrl_s ctrl,
	input wire logic idr_tick,
	input wire logic [SAMPLE_W-1:0] sample_in,
	output logic odr_tick,
	output logic [SAMPLE_W-1:0] out_data,
	output logic fifo_push,
	input wire logic fifo_pop,
	output logic [5:0] fifo_count,
	output logic [2:0] irq_pending,
	output logic burst_mode,
	input wire logic burst_start,
	input wire logic [7:0] burst_addr,
	input wire logic burst_next,
	output logic [7:0] ptr_addr
);
	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	// Divisor for each select code; zero means pass-through
	function automatic logic [DEC_CNT_W-1:0] divisor(input logic [DEC_MSB:0] sel);
		logic [DEC_CNT_W-1:0] d;
		d = 10'h001;
		unique case (sel)
			4'h0: d = 10'h001;
			4'h1: d = 10'h002;
			4'h2: d = 10'h004;
			4'h3: d = 10'h005;
			4'h4: d = 10'h008;
			4'h5: d = 10'h00a;
			4'h6: d = 10'h010;
			4'h7: d = 10'h014;
			4'h8: d = 10'h028;
			4'h9: d = 10'h043;
			4'ha: d = 10'h050;
			// Codes b to e pair up: two at 200, two at 500
			4'hb: d = 10'h0c8;
			4'hc: d = 10'h0c8;
			4'hd: d = 10'h1f4;
			4'he: d = 10'h1f4;
			4'hf: d = 10'h3e8;
		endcase
		return d;
	endfunction

	// -----------------------------------------------------------------
	// Register file
	// -----------------------------------------------------------------
	logic [WM_MSB:0] watermark_level;
	logic [7:0] burst_dec;
	logic [WM_MSB:0] next_watermark_level;
	logic [7:0] next_burst_dec;
	logic [7:0] next_reg_rdata;
	logic [DEC_MSB:0] decimation_divisor_sel;

	assign decimation_divisor_sel = burst_dec[DEC_MSB:0];
	assign burst_mode = burst_dec[BIT_BURST]; // RULE_15

	// Writes; reserved bits are never stored so they read back as zero
	always_comb
	begin
		next_watermark_level = watermark_level;
		next_burst_dec = burst_dec;
		if (reg_wr && reg_addr == ADDR_WATERMARK)
			next_watermark_level = reg_wdata[WM_MSB:0]; // RULE_01
		if (reg_wr && reg_addr == ADDR_BURST_DEC)
			next_burst_dec = reg_wdata & BURST_DEC_WMASK;
	end

	// Read data is registered, one cycle after the strobe
	always_comb
	begin
		next_reg_rdata = reg_rdata;
		if (reg_rd)
		begin
			unique case (reg_addr)
				ADDR_WATERMARK: next_reg_rdata = {3'h0, watermark_level}; // RULE_03
				ADDR_PENDING: next_reg_rdata = {5'h00, irq_pending}; // RULE_06
				ADDR_BURST_DEC: next_reg_rdata = burst_dec;
				default: next_reg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			watermark_level <= WM_RESET[WM_MSB:0]; // RULE_01
			burst_dec <= BURST_DEC_RESET; // RULE_08
			reg_rdata <= 8'h00;
		end
		else
		begin
			watermark_level <= next_watermark_level;
			burst_dec <= next_burst_dec;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Hit decode for the host mux; combinational on purpose
	assign reg_hit = reg_addr == ADDR_WATERMARK || reg_addr == ADDR_PENDING || reg_addr == ADDR_BURST_DEC;

	// -----------------------------------------------------------------
	// Decimator
	// -----------------------------------------------------------------
	logic [DEC_CNT_W-1:0] dec_cnt;
	logic [DEC_CNT_W-1:0] next_dec_cnt;
	logic dec_last;

	// Counts timebase ticks only, so any base rate works
	assign dec_last = dec_cnt >= divisor(decimation_divisor_sel) - 10'h001; // RULE_13
	assign odr_tick = idr_tick && (decimation_divisor_sel == 4'h0 || dec_last); // RULE_07 RULE_11

	// A select change mid-count is caught by the >= compare, no lockup
	always_comb
	begin
		next_dec_cnt = dec_cnt;
		if (decimation_divisor_sel == 4'h0)
			next_dec_cnt = '0; // RULE_08
		else if (idr_tick)
			next_dec_cnt = dec_last ? '0 : dec_cnt + 10'h001; // RULE_09 RULE_10
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			dec_cnt <= '0;
		else
			dec_cnt <= next_dec_cnt;
	end

	// -----------------------------------------------------------------
	// Output data register and FIFO occupancy
	// -----------------------------------------------------------------
	logic [SAMPLE_W-1:0] next_out_data;
	logic [5:0] next_fifo_count;
	logic fifo_take;

	// Storage lives beside the read mux; this block owns the occupancy
	assign fifo_push = odr_tick && ctrl.fifo_enable && fifo_count < FIFO_DEPTH
		&& !(ctrl.watermark_mode && fifo_count >= {1'b0, watermark_level}); // RULE_19
	// A pop on an empty FIFO must not wrap the count
	assign fifo_take = fifo_pop && fifo_count != 6'h00;

	always_comb
	begin
		next_out_data = odr_tick ? sample_in : out_data; // RULE_12
		next_fifo_count = fifo_count;
		if (ctrl.fifo_flush)
			next_fifo_count = 6'h00;
		else if (fifo_push && !fifo_take)
			next_fifo_count = fifo_count + 6'h01;
		else if (fifo_take && !fifo_push)
			next_fifo_count = fifo_count - 6'h01;
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			out_data <= '0;
			fifo_count <= 6'h00;
		end
		else
		begin
			out_data <= next_out_data;
			fifo_count <= next_fifo_count;
		end
	end

	// -----------------------------------------------------------------
	// Pending flags
	// -----------------------------------------------------------------
	logic [2:0] next_irq_pending;

	// Level flags from the updated count, gated by each enable
	always_comb
	begin
		next_irq_pending = irq_pending;
		if (odr_tick || fifo_pop || ctrl.fifo_flush) // RULE_22
		begin
			next_irq_pending[BIT_EMPTY] = ctrl.empty_irq_enable && next_fifo_count == 6'h00; // RULE_05
			next_irq_pending[BIT_FULL] = ctrl.full_irq_enable && next_fifo_count == FIFO_DEPTH; // RULE_04
			next_irq_pending[BIT_LEVEL] = ctrl.level_irq_enable
				&& next_fifo_count >= {1'b0, watermark_level}; // RULE_04
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			irq_pending <= PENDING_RESET[2:0];
		else
			irq_pending <= next_irq_pending;
	end

	// -----------------------------------------------------------------
	// Burst address pointer
	// -----------------------------------------------------------------
	logic [7:0] next_ptr_addr;
	logic [7:0] wrap_at;

	assign wrap_at = burst_dec[BIT_WRAP_SEL] ? WRAP_HI : WRAP_LO; // RULE_17

	// Start wins over next; wrap only while wrap is enabled
	always_comb
	begin
		next_ptr_addr = ptr_addr;
		if (burst_start)
			next_ptr_addr = burst_addr;
		else if (burst_next)
		begin
			if (!burst_dec[BIT_WRAP_N] && ptr_addr == wrap_at)
				next_ptr_addr = WRAP_BASE; // RULE_16
			else
				next_ptr_addr = ptr_addr + 8'h01; // RULE_18
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			ptr_addr <= 8'h00;
		else
			ptr_addr <= next_ptr_addr;
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	// Register reset and read-back; read data lands one edge after the strobe
	chk_wm_reset: assert property (!$past(nrst) |-> watermark_level == WM_RESET[WM_MSB:0]) // RULE_01
		else $error("watermark not at reset value");
	chk_wm_resv: assert property (reg_rd && reg_addr == ADDR_WATERMARK |=> reg_rdata[7:5] == 3'h0) // RULE_03
		else $error("watermark reserved bits nonzero");
	chk_pend_resv: assert property (reg_rd && reg_addr == ADDR_PENDING // RULE_06
		|=> reg_rdata == {5'h00, $past(irq_pending)})
		else $error("pending read wrong");

	// Flags rise only under their enables and follow the count
	chk_level_enable: assert property ($rose(irq_pending[BIT_LEVEL]) |-> $past(ctrl.level_irq_enable)) // RULE_05
		else $error("level flag set while disabled");
	chk_empty_enable: assert property ($rose(irq_pending[BIT_EMPTY]) |-> $past(ctrl.empty_irq_enable)) // RULE_05
		else $error("empty flag set while disabled");
	chk_full_enable: assert property ($rose(irq_pending[BIT_FULL]) |-> $past(ctrl.full_irq_enable)) // RULE_05
		else $error("full flag set while disabled");
	chk_full_flag: assert property ((odr_tick || fifo_pop) && !ctrl.fifo_flush && ctrl.full_irq_enable // RULE_22
		&& fifo_count == FIFO_DEPTH && !fifo_pop |=> irq_pending[BIT_FULL])
		else $error("full flag missing");
	chk_empty_flag: assert property (fifo_pop && !fifo_push && !ctrl.fifo_flush && ctrl.empty_irq_enable // RULE_22
		&& fifo_count == 6'h01 |=> irq_pending[BIT_EMPTY])
		else $error("empty flag missing");
	chk_level_flag: assert property ((odr_tick || fifo_pop) && !ctrl.fifo_flush && ctrl.level_irq_enable // RULE_22
		&& fifo_count > {1'b0, watermark_level} |=> irq_pending[BIT_LEVEL])
		else $error("level flag missing");
	chk_count_cap: assert property (fifo_count <= FIFO_DEPTH) // RULE_04
		else $error("occupancy past capacity");

	// Decimator pacing; the counter advances only on timebase ticks and clears while decimation is off
	chk_no_decim: assert property (decimation_divisor_sel == 4'h0 && idr_tick |-> odr_tick) // RULE_11
		else $error("sample lost with decimation off");
	chk_dec_idle: assert property (decimation_divisor_sel == 4'h0 |=> dec_cnt == 10'h000) // RULE_08
		else $error("decimator counting while off");
	chk_div_two: assert property (odr_tick && decimation_divisor_sel == 4'h1 ##1 // RULE_09
		idr_tick && $stable(decimation_divisor_sel) |-> !odr_tick ##1 (!idr_tick || odr_tick))
		else $error("divide by two wrong");
	chk_out_rate: assert property ($changed(out_data) |-> $past(odr_tick)) // RULE_12
		else $error("output data changed off output rate");

	// Watermark drop and burst pointer
	chk_wm_drop: assert property (ctrl.watermark_mode && fifo_count >= {1'b0, watermark_level} // RULE_19
		|=> fifo_count <= $past(fifo_count))
		else $error("sample stored past watermark");
	chk_wrap_lo: assert property (burst_next && !burst_start && !burst_dec[BIT_WRAP_N] // RULE_17
		&& !burst_dec[BIT_WRAP_SEL] && ptr_addr == WRAP_LO |=> ptr_addr == WRAP_BASE)
		else $error("no wrap at low point");
	chk_wrap_hi: assert property (burst_next && !burst_start && !burst_dec[BIT_WRAP_N] // RULE_17
		&& burst_dec[BIT_WRAP_SEL] && ptr_addr == WRAP_HI |=> ptr_addr == WRAP_BASE)
		else $error("no wrap at high point");
	chk_incr: assert property (burst_next && !burst_start && burst_dec[BIT_WRAP_N] // RULE_18
		|=> ptr_addr == $past(ptr_addr) + 8'h01)
		else $error("pointer did not increment");

	// Main scenarios
	cov_wrap_hi: cover property (burst_next && burst_dec[BIT_WRAP_SEL] && ptr_addr == WRAP_HI);
	cov_fill: cover property (fifo_push && fifo_count == FIFO_DEPTH - 6'h01);
	cov_div_max: cover property (odr_tick && decimation_divisor_sel == 4'hf);
	cov_wm_drop: cover property (odr_tick && ctrl.fifo_enable && ctrl.watermark_mode && !fifo_push);
	cov_level_set: cover property ($rose(irq_pending[BIT_LEVEL]));
endmodule

// *** verification/ftdc_host.sv ***
`timescale 1ns/10ps
// Host stand-in: byte register bus, FIFO drain and burst pointer commands
module ftdc_host
(
	input wire logic mclk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	output logic fifo_pop,
	output logic burst_start,
	output logic [7:0] burst_addr,
	output logic burst_next
);
	// Idle bus at time zero
	initial
	begin
		{reg_addr, reg_wr, reg_wdata, reg_rd, fifo_pop, burst_start, burst_addr, burst_next} = '0;
	end
	// One-cycle write strobe; callers keep watermark 1..31, never zero
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Read data is registered, so take it one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		v = reg_rdata;
	endtask
	// Single-sample drain, burst mode not needed
	task automatic pop;
		@(posedge mclk);
		fifo_pop <= 1'b1;
		@(posedge mclk);
		fifo_pop <= 1'b0;
	endtask
	// Load pointer, then advance one byte; burst bit set first by caller
	task automatic ptr(input logic [7:0] a);
		@(posedge mclk);
		burst_addr <= a;
		burst_start <= 1'b1;
		@(posedge mclk);
		burst_start <= 1'b0;
		burst_next <= 1'b1;
		@(posedge mclk);
		burst_next <= 1'b0;
		#1;
	endtask
endmodule

// *** verification/fifo_threshold_decimation_ctrl_tb.sv ***
`timescale 1ns/10ps
module fifo_threshold_decimation_ctrl_tb import ftdc_pkg::*;;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	ftdc_ctrl_s ctrl = '0;
	logic idr_tick = 1'b0;
	logic [SAMPLE_W-1:0] sample_in = '0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, burst_addr, ptr_addr, d;
	logic reg_wr, reg_rd, reg_hit, odr_tick, fifo_push, fifo_pop, burst_mode, burst_start, burst_next;
	logic [SAMPLE_W-1:0] out_data, smp;
	logic [5:0] fifo_count;
	logic [2:0] irq_pending;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	// -----------------------------------------------------------------
	// Clock, sample ramp, hang guard
	// -----------------------------------------------------------------
	always #5 mclk = ~mclk;
	// Ramp keeps every sample distinct
	always @(posedge mclk) sample_in <= sample_in + 48'h1;
	// Decimation sweep needs about 6000 cycles
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			end_sim();
		end
	end
	ftdc_ctrl uut (
		.mclk(mclk),
		.nrst(nrst),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.reg_hit(reg_hit),
		.ctrl(ctrl),
		.idr_tick(idr_tick),
		.sample_in(sample_in),
		.odr_tick(odr_tick),
		.out_data(out_data),
		.fifo_push(fifo_push),
		.fifo_pop(fifo_pop),
		.fifo_count(fifo_count),
		.irq_pending(irq_pending),
		.burst_mode(burst_mode),
		.burst_start(burst_start),
		.burst_addr(burst_addr),
		.burst_next(burst_next),
		.ptr_addr(ptr_addr)
	);
	ftdc_host host (
		.mclk(mclk),
		.reg_rdata(reg_rdata),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.reg_rd(reg_rd),
		.fifo_pop(fifo_pop),
		.burst_start(burst_start),
		.burst_addr(burst_addr),
		.burst_next(burst_next)
	);
	// -----------------------------------------------------------------
	// Shared helpers
	// -----------------------------------------------------------------
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk("reg", e, d);
	endtask
	// n internal-rate ticks back to back, then let registers settle
	task automatic run(input int n, input ftdc_ctrl_s c);
		@(posedge mclk);
		ctrl <= c;
		// Zero ticks must not raise and drop the strobe in one step
		if (n > 0)
		begin
			idr_tick <= 1'b1;
			repeat (n) @(posedge mclk);
			idr_tick <= 1'b0;
		end
		@(posedge mclk);
		#1;
	endtask
	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_regs;
		rdc(ADDR_WATERMARK, WM_RESET);
		rdc(ADDR_PENDING, PENDING_RESET);
		rdc(ADDR_BURST_DEC, BURST_DEC_RESET);
		host.wr(ADDR_WATERMARK, 8'hff);
		rdc(ADDR_WATERMARK, 8'h1f);
		host.wr(ADDR_PENDING, 8'hff);
		rdc(ADDR_PENDING, 8'h00);
		host.wr(ADDR_BURST_DEC, 8'hff);
		rdc(ADDR_BURST_DEC, BURST_DEC_WMASK);
		chk("burst", 48'h1, burst_mode);
		chk("hit", 48'h1, reg_hit);
		rdc(8'h31, 8'h00);
		chk("hit", 48'h0, reg_hit);
		$display("test regs done");
	endtask
	task automatic t_dec;
		int dv[16] = '{1, 2, 4, 5, 8, 10, 16, 20, 40, 67, 80, 200, 200, 500, 500, 1000};
		int n;
		for (int c = 0; c < 16; c++)
		begin
			host.wr(ADDR_BURST_DEC, 8'(c));
			idr_tick <= 1'b1;
			// First strobe lines the count up after the select change
			n = 0;
			do
			begin
				@(posedge mclk);
				#1;
				n++;
			end
			while (odr_tick !== 1'b1 && n < 1100);
			smp = sample_in;
			n = 0;
			do
			begin
				@(posedge mclk);
				#1;
				n++;
				if (n == 1)
					chk("out", smp, out_data);
			end
			while (odr_tick !== 1'b1 && n < 1100);
			chk("div", 48'(dv[c]), 48'(n));
			// Strobe drops on an edge, so the last output tick is taken
			@(posedge mclk);
			idr_tick <= 1'b0;
		end
		host.wr(ADDR_BURST_DEC, 8'h00);
		$display("test decimation done");
	endtask
	task automatic t_fifo;
		host.wr(ADDR_WATERMARK, 8'h03);
		run(0, 6'h0f);
		chk("pend", 48'h1, irq_pending);
		run(5, 6'h37);
		chk("count", 48'h3, fifo_count);
		// One more tick at the level: that sample must be dropped
		@(posedge mclk);
		idr_tick <= 1'b1;
		#1;
		chk("push", 48'h0, fifo_push);
		@(posedge mclk);
		idr_tick <= 1'b0;
		rdc(ADDR_PENDING, 8'h04);
		repeat (3) host.pop();
		#1;
		chk("pend", 48'h1, irq_pending);
		@(posedge mclk);
		ctrl <= 6'h36;
		host.pop();
		#1;
		chk("pend", 48'h0, irq_pending);
		run(40, 6'h27);
		chk("count", 48'h20, fifo_count);
		chk("pend", 48'h6, irq_pending);
		run(0, 6'h0f);
		chk("count", 48'h0, fifo_count);
		$display("test fifo done");
	endtask
	task automatic t_ptr;
		logic [7:0] pc[4] = '{8'h00, 8'h20, 8'h20, 8'h10};
		logic [7:0] pa[4] = '{8'h12, 8'h14, 8'h12, 8'h12};
		logic [7:0] pe[4] = '{8'h0d, 8'h0d, 8'h13, 8'h13};
		for (int i = 0; i < 4; i++)
		begin
			host.wr(ADDR_BURST_DEC, pc[i] | 8'h80);
			host.ptr(pa[i]);
			chk("ptr", pe[i], ptr_addr);
		end
		$display("test pointer done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Reset for 20 cycles, then the scenarios in turn
	initial
	begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		t_regs();
		t_dec();
		t_fifo();
		t_ptr();
		end_sim();
	end
endmodule
